// *** hdl/uif_cfg.svh ***
// Register map, field positions, reset values and timing counts
// Assumes a 125 MHz pclk and word-aligned APB byte addresses
`ifndef UIF_CFG_SVH
`define UIF_CFG_SVH

// ==========================================================
// Register byte offsets
`define UIF_OFS_USB_FLAGS 8'h00
`define UIF_OFS_USB_EN 8'h04
`define UIF_OFS_OTG_FLAGS 8'h08
`define UIF_OFS_OTG_EN 8'h0c
`define UIF_OFS_ERR_EN 8'h10
`define UIF_OFS_CTRL 8'h14
`define UIF_OFS_XFER_STAT 8'h18

// ==========================================================
// Field positions
`define UIF_B_STALL 7
`define UIF_B_ATTACH 6
`define UIF_B_RESUME 5
`define UIF_B_IDLE 4
`define UIF_B_TOKEN 3
`define UIF_B_SOF 2
`define UIF_B_ERRSUM 1
`define UIF_B_RST_DET 0
`define UIF_B_ID 7
`define UIF_B_MS 6
`define UIF_B_LSTABLE 5
`define UIF_B_ACTV 4
`define UIF_B_SESVD 3
`define UIF_B_SESEND 2
`define UIF_B_VBUSVD 0
`define UIF_B_HOST 0
`define UIF_B_LOWSPD 1

// ==========================================================
// Implemented bit masks and reset values
`define UIF_OTG_MASK 8'hfd
`define UIF_ERR_MASK 8'hbf
`define UIF_CTRL_MASK 8'h03
`define UIF_RST_BYTE 8'h00

// ==========================================================
// Timing
`define UIF_CLK_MHZ 125
`define UIF_T_LINE_NS 2500
`define UIF_C_LINE ((`UIF_T_LINE_NS * `UIF_CLK_MHZ + 999) / 1000)
`define UIF_T_IDLE_US 3000
`define UIF_C_IDLE (`UIF_T_IDLE_US * `UIF_CLK_MHZ)
`define UIF_T_MS_US 1000
`define UIF_C_MS (`UIF_T_MS_US * `UIF_CLK_MHZ)

`endif

// *** hdl/uif_pkg.sv ***
// Types shared by the interrupt flag logic
// Assumes uif_cfg.svh supplies the numeric constants
package uif_pkg;
  typedef logic [7:0] uif_byte_t;
  typedef logic [18:0] uif_cnt_t;
  typedef enum logic [1:0] {LINE_SE0, LINE_J, LINE_K, LINE_SE1} uif_line_t;
endpackage

// *** hdl/uif_line_if.sv ***
// Line event bundle between the line monitor and the flag core
// Assumes both ends run on pclk
`timescale 1ns/1ps
interface uif_line_if;
  logic low_speed;
  logic resume;
  logic se0_long;
  logic idle;
  logic attach;
  logic activity;
  logic lstable;
  logic ms_tick;
  modport mon (input low_speed, output resume, se0_long, idle, attach,
    activity, lstable, ms_tick);
  modport core (output low_speed, input resume, se0_long, idle, attach,
    activity, lstable, ms_tick);
endinterface

// *** hdl/uif_line_mon.sv ***
// Line monitor: D+/D- synchroniser and persistence detectors
// Assumes dp_i and dm_i are asynchronous pins
`timescale 1ns/1ps
`include "uif_cfg.svh"
module uif_line_mon #(
  parameter int unsigned IDLE_CYC = `UIF_C_IDLE,
  parameter int unsigned MS_CYC = `UIF_C_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dp_i,
  input wire logic dm_i,
  uif_line_if.mon lm
);
  import uif_pkg::*;

  // ==========================================================
  // Synchroniser and line decode
  logic [1:0] dp_s_q;
  logic [1:0] dm_s_q;
  uif_line_t line_now;
  uif_line_t line_q;
  uif_line_t last_q;
  logic changed;
  logic [4:0] cond;
  logic [4:0] hit;
  uif_cnt_t thr [5];
  uif_cnt_t ms_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dp_s_q <= 2'h0;
      dm_s_q <= 2'h0;
    end else begin
      dp_s_q <= {dp_s_q[0], dp_i};
      dm_s_q <= {dm_s_q[0], dm_i};
    end
  end

  always_comb begin
    unique case ({dp_s_q[1], dm_s_q[1]})
      2'b00: line_now = LINE_SE0;
      2'b11: line_now = LINE_SE1;
      2'b10: line_now = lm.low_speed ? LINE_K : LINE_J;
      2'b01: line_now = lm.low_speed ? LINE_J : LINE_K;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) line_q <= LINE_SE0;
    else line_q <= line_now;
  end

  assign changed = (line_now != line_q);
  assign cond[0] = (line_now == LINE_K);
  assign cond[1] = (line_now == LINE_SE0);
  assign cond[2] = (line_now == LINE_J);
  assign cond[3] = (line_now != LINE_SE0) && !changed;
  assign cond[4] = !changed;

  always_comb begin
    thr[0] = 19'(`UIF_C_LINE);
    thr[1] = 19'(`UIF_C_LINE);
    thr[2] = 19'(IDLE_CYC);
    thr[3] = 19'(`UIF_C_LINE);
    thr[4] = 19'(MS_CYC);
  end

  // ==========================================================
  // Persistence counters, one shot per run since they saturate
  for (genvar i = 0; i < 5; i++) begin : g_run
    uif_cnt_t cnt_q;
    assign hit[i] = cond[i] && (cnt_q == thr[i] - 19'h1);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_q <= 19'h0;
      else if (!cond[i]) cnt_q <= 19'h0;
      else if (cnt_q != thr[i]) cnt_q <= cnt_q + 19'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) last_q <= LINE_SE0;
    else if (hit[4]) last_q <= line_now;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ms_q <= 19'h0;
    else if (ms_q == 19'(MS_CYC) - 19'h1) ms_q <= 19'h0;
    else ms_q <= ms_q + 19'h1;
  end

  assign lm.resume = hit[0];
  assign lm.se0_long = hit[1];
  assign lm.idle = hit[2];
  assign lm.attach = hit[3];
  assign lm.lstable = hit[4] && (line_now != last_q);
  assign lm.activity = changed;
  assign lm.ms_tick = (ms_q == 19'(MS_CYC) - 19'h1);

  // ==========================================================
  // Checks
  // Resume after full K run
  property p_resume_len;
    @(posedge pclk) disable iff (!presetn)
      hit[0] |-> g_run[0].cnt_q == 19'(`UIF_C_LINE) - 19'h1 &&
        $past(cond[0]);
  endproperty
  a_resume_len: assert property (p_resume_len)
    else $error("resume fired without full K run");

  property p_se0_once;
    @(posedge pclk) disable iff (!presetn)
      hit[1] ##1 cond[1] |-> !hit[1];
  endproperty
  a_se0_once: assert property (p_se0_once)
    else $error("reset/detach retriggered inside one SE0");

  // Idle only after the idle count
  property p_idle_len;
    @(posedge pclk) disable iff (!presetn)
      hit[2] |-> g_run[2].cnt_q == 19'(IDLE_CYC) - 19'h1;
  endproperty
  a_idle_len: assert property (p_idle_len)
    else $error("idle fired early");
endmodule

// *** hdl/uif_flags_top.sv ***
// USB interrupt status, enable and request logic behind an APB slave
// Assumes event inputs are one-cycle pulses on pclk; dp_i/dm_i are pins
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`include "uif_cfg.svh"

// Function
// - Dual-role enable holds seven read/write enables, bits 7..2 and 0.
// - Stall flag bit 7 sets when a STALL handshake was sent.
// - Resume flag sets after K-state held 2.5 us, polarity by speed.
// - Idle flag bit 4 sets after idle state held 3 ms.
// - Token flag bit 3 sets on token done; clearing advances status FIFO.
// - Frame flag bit 2: SOF received as device, threshold reached as host.
// - Error summary bit 1 is read-only, set by enabled error flags.
// - Device bus-reset flag sets after 2.5 us reset, once per reset.
// - Host attach flag sets when not SE0 and quiet for 2.5 us.
// - Host detach flag bit 0, once per SE0 run.
// - Attach enable and flag bit 6 read zero in device mode.
// - Flags clear on write one; write zero leaves them.
// - Enable bits gate the same-position flags; bit 0 gates reset/detach.
// - Line-stable flag sets when line stable 1 ms and changed.
// - Error flags are masked by their error-enable bits.
module uif_flags_top #(
  parameter int unsigned IDLE_CYC = `UIF_C_IDLE,
  parameter int unsigned MS_CYC = `UIF_C_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dp_i,
  input wire logic dm_i,
  input wire logic stall_sent_i,
  input wire logic sof_rx_i,
  input wire logic sof_thresh_i,
  input wire logic token_done_i,
  input wire uif_pkg::uif_byte_t token_stat_i,
  input wire uif_pkg::uif_byte_t err_flags_i,
  input wire logic id_change_i,
  input wire logic sess_valid_chg_i,
  input wire logic b_sess_end_chg_i,
  input wire logic a_vbus_valid_chg_i,
  output logic irq_o
);
  import uif_pkg::*;

  // ==========================================================
  // Declarations
  uif_line_if lm ();
  uif_byte_t usb_flags_q;
  uif_byte_t usb_en_q;
  uif_byte_t otg_flags_q;
  uif_byte_t otg_en_q;
  uif_byte_t err_en_q;
  uif_byte_t ctrl_q;
  uif_byte_t usb_set;
  uif_byte_t otg_set;
  uif_byte_t usb_rd;
  uif_byte_t usb_en_rd;
  uif_byte_t rd_byte;
  uif_byte_t fifo_mem [4];
  logic [2:0] wp_q;
  logic [2:0] rp_q;
  logic [2:0] fifo_cnt;
  logic fifo_full;
  logic fifo_empty;
  logic push;
  logic pop;
  logic host_mode;
  logic err_sum;
  logic setup;
  logic wr_acc;
  logic addr_ok;
  logic wr_usb_flags;
  logic wr_otg_flags;
  logic irq_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;

  uif_line_mon #(
    .IDLE_CYC(IDLE_CYC),
    .MS_CYC(MS_CYC)
  ) u_line_mon (
    .pclk(pclk),
    .presetn(presetn),
    .dp_i(dp_i),
    .dm_i(dm_i),
    .lm(lm)
  );

  assign host_mode = ctrl_q[`UIF_B_HOST];
  assign lm.low_speed = ctrl_q[`UIF_B_LOWSPD];

  // ==========================================================
  // APB decode
  // Zero wait state: pready rises in the access phase from a flop
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready_q && pwrite;

  always_comb begin
    unique case (paddr)
      `UIF_OFS_USB_FLAGS, `UIF_OFS_USB_EN, `UIF_OFS_OTG_FLAGS,
      `UIF_OFS_OTG_EN, `UIF_OFS_ERR_EN, `UIF_OFS_CTRL,
      `UIF_OFS_XFER_STAT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign wr_usb_flags = wr_acc && (paddr == `UIF_OFS_USB_FLAGS);
  assign wr_otg_flags = wr_acc && (paddr == `UIF_OFS_OTG_FLAGS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !addr_ok;
    end
  end

  // ==========================================================
  // Enable and control registers
  // Dual-role enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) otg_en_q <= `UIF_RST_BYTE;
    else if (wr_acc && paddr == `UIF_OFS_OTG_EN)
      otg_en_q <= pwdata[7:0] & `UIF_OTG_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) usb_en_q <= `UIF_RST_BYTE;
    else if (wr_acc && paddr == `UIF_OFS_USB_EN) usb_en_q <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) err_en_q <= `UIF_RST_BYTE;
    else if (wr_acc && paddr == `UIF_OFS_ERR_EN)
      err_en_q <= pwdata[7:0] & `UIF_ERR_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_q <= `UIF_RST_BYTE;
    else if (wr_acc && paddr == `UIF_OFS_CTRL)
      ctrl_q <= pwdata[7:0] & `UIF_CTRL_MASK;
  end

  // ==========================================================
  // Transfer status FIFO
  // A token that finds the FIFO full is dropped and does not set the flag
  assign fifo_cnt = wp_q - rp_q;
  assign fifo_full = (fifo_cnt == 3'h4);
  assign fifo_empty = (fifo_cnt == 3'h0);
  assign push = token_done_i && !fifo_full;
  assign pop = wr_usb_flags && pwdata[`UIF_B_TOKEN] &&
    usb_flags_q[`UIF_B_TOKEN] && !fifo_empty;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= 3'h0;
      rp_q <= 3'h0;
    end else begin
      if (push) wp_q <= wp_q + 3'h1;
      if (pop) rp_q <= rp_q + 3'h1;
    end
  end

  always_ff @(posedge pclk) begin
    if (push) fifo_mem[wp_q[1:0]] <= token_stat_i;
  end

  // ==========================================================
  // USB flags
  // Summary from enabled errors
  assign err_sum = |(err_flags_i & err_en_q);

  always_comb begin
    usb_set = 8'h00;
    usb_set[`UIF_B_STALL] = stall_sent_i;
    usb_set[`UIF_B_ATTACH] = host_mode && lm.attach;
    usb_set[`UIF_B_RESUME] = lm.resume;
    usb_set[`UIF_B_IDLE] = lm.idle;
    usb_set[`UIF_B_TOKEN] = push || (pop && fifo_cnt > 3'h1);
    usb_set[`UIF_B_SOF] = host_mode ? sof_thresh_i : sof_rx_i;
    usb_set[`UIF_B_RST_DET] = lm.se0_long;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) usb_flags_q <= `UIF_RST_BYTE;
    else if (wr_usb_flags)
      usb_flags_q <= (usb_flags_q & ~pwdata[7:0]) | usb_set;
    else usb_flags_q <= usb_flags_q | usb_set;
  end

  // Bit 6 hidden in device mode
  always_comb begin
    usb_rd = usb_flags_q;
    usb_rd[`UIF_B_ERRSUM] = err_sum;
    usb_rd[`UIF_B_ATTACH] = host_mode && usb_flags_q[`UIF_B_ATTACH];
    usb_en_rd = usb_en_q;
    usb_en_rd[`UIF_B_ATTACH] = host_mode && usb_en_q[`UIF_B_ATTACH];
  end

  // ==========================================================
  // Dual-role flags
  always_comb begin
    otg_set = 8'h00;
    otg_set[`UIF_B_ID] = id_change_i;
    otg_set[`UIF_B_MS] = lm.ms_tick;
    otg_set[`UIF_B_LSTABLE] = lm.lstable;
    otg_set[`UIF_B_ACTV] = lm.activity;
    otg_set[`UIF_B_SESVD] = sess_valid_chg_i;
    otg_set[`UIF_B_SESEND] = b_sess_end_chg_i;
    otg_set[`UIF_B_VBUSVD] = a_vbus_valid_chg_i;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) otg_flags_q <= `UIF_RST_BYTE;
    else if (wr_otg_flags)
      otg_flags_q <= (otg_flags_q & ~pwdata[7:0]) | otg_set;
    else otg_flags_q <= otg_flags_q | otg_set;
  end

  // ==========================================================
  // Read data, captured in the setup phase
  always_comb begin
    unique case (paddr)
      `UIF_OFS_USB_FLAGS: rd_byte = usb_rd;
      `UIF_OFS_USB_EN: rd_byte = usb_en_rd;
      `UIF_OFS_OTG_FLAGS: rd_byte = otg_flags_q;
      `UIF_OFS_OTG_EN: rd_byte = otg_en_q;
      `UIF_OFS_ERR_EN: rd_byte = err_en_q;
      `UIF_OFS_CTRL: rd_byte = ctrl_q;
      `UIF_OFS_XFER_STAT:
        rd_byte = fifo_empty ? 8'h00 : fifo_mem[rp_q[1:0]];
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_q <= 32'h0;
    else if (setup && !pwrite) prdata_q <= {24'h0, rd_byte};
  end

  // ==========================================================
  // Interrupt request
  // Same-position gating
  assign irq_d = |(usb_rd & usb_en_rd) || |(otg_flags_q & otg_en_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_q <= 1'b0;
    else irq_q <= irq_d;
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq_o = irq_q;

  // ==========================================================
  // Checks
  property p_w1c;
    @(posedge pclk) disable iff (!presetn)
      wr_usb_flags && pwdata[`UIF_B_IDLE] && !lm.idle
        |=> !usb_flags_q[`UIF_B_IDLE];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear idle flag");

  property p_w0_keep;
    @(posedge pclk) disable iff (!presetn)
      wr_usb_flags && !pwdata[`UIF_B_STALL] && usb_flags_q[`UIF_B_STALL]
        |=> usb_flags_q[`UIF_B_STALL];
  endproperty
  a_w0_keep: assert property (p_w0_keep)
    else $error("write zero cleared stall flag");

  property p_stall_set;
    @(posedge pclk) disable iff (!presetn)
      stall_sent_i |=> usb_flags_q[`UIF_B_STALL];
  endproperty
  a_stall_set: assert property (p_stall_set)
    else $error("stall event lost");

  property p_sof_role;
    @(posedge pclk) disable iff (!presetn)
      sof_rx_i && !sof_thresh_i && host_mode && !usb_flags_q[`UIF_B_SOF]
        && !$past(sof_thresh_i) |=> !usb_flags_q[`UIF_B_SOF];
  endproperty
  a_sof_role: assert property (p_sof_role)
    else $error("host frame flag set by received token");

  property p_attach_dev;
    @(posedge pclk) disable iff (!presetn)
      !host_mode |-> !usb_rd[`UIF_B_ATTACH] && !usb_en_rd[`UIF_B_ATTACH];
  endproperty
  a_attach_dev: assert property (p_attach_dev)
    else $error("attach bit visible in device mode");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      (|(usb_flags_q & usb_en_q & 8'h80)) ##1 usb_flags_q[`UIF_B_STALL]
        && usb_en_q[`UIF_B_STALL] |-> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled stall flag gave no request");

  property p_fifo_adv;
    @(posedge pclk) disable iff (!presetn)
      pop |=> rp_q == $past(rp_q) + 3'h1;
  endproperty
  a_fifo_adv: assert property (p_fifo_adv)
    else $error("token clear did not advance status FIFO");

  property p_hi_zero;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite |-> prdata[31:8] == 24'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero)
    else $error("upper read bits not zero");

  property p_errsum;
    @(posedge pclk) disable iff (!presetn)
      err_en_q == 8'h00 |-> !usb_rd[`UIF_B_ERRSUM];
  endproperty
  a_errsum: assert property (p_errsum)
    else $error("error summary set with all errors masked");
endmodule

// *** dv/uif_cpu_model.sv ***
// Processor core stand-in: an APB master issuing whole-word transfers
// Assumes one pclk domain; the slave must raise pready within 64 cycles of the access phase
`timescale 1ns/1ps
module uif_cpu_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ==========================================================
  // Idle bus
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // ==========================================================
  // One transfer
  // whole-word writes
  // A read-modify-write would wipe every pending flag, so the core
  // always writes the full word with ones only where it clears
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e,
    output bit hung);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    hung = (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep showing the last value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the interrupt flag block
// Assumes the core model above as bus master and short idle and 1 ms counts
`timescale 1ns/1ps
`include "uif_cfg.svh"
module tb_top;
  import uif_pkg::*;
  localparam int IDLE = 50;
  localparam int MSC = 40;
  localparam int LINE = 330;
  localparam logic [7:0] EVB [8] = '{8'h80, 8'h04, 8'h04, 8'h08,
    8'h80, 8'h08, 8'h04, 8'h01};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_o;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic dp_i, dm_i;
  logic [7:0] ev;
  uif_byte_t token_stat_i, err_flags_i;
  int bad_count = 0, samples_checked = 0;
  int mf = 0, me = 0, of = 0, oe = 0, ee = 0, ctl = 0, ef = 0;
  int q[$];
  logic [7:0] a;

  // ==========================================================
  // Clock and instances
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  uif_cpu_model uif_cpu_model_i (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  uif_flags_top #(.IDLE_CYC(IDLE), .MS_CYC(MSC)) uif_flags_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dp_i(dp_i), .dm_i(dm_i),
    .stall_sent_i(ev[0]), .sof_rx_i(ev[1]), .sof_thresh_i(ev[2]),
    .token_done_i(ev[3]), .token_stat_i(token_stat_i),
    .err_flags_i(err_flags_i), .id_change_i(ev[4]),
    .sess_valid_chg_i(ev[5]), .b_sess_end_chg_i(ev[6]),
    .a_vbus_valid_chg_i(ev[7]), .irq_o(irq_o));

  // ==========================================================
  // Reference model and checks
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic bit mapped(logic [7:0] x);
    return x inside {`UIF_OFS_USB_FLAGS, `UIF_OFS_USB_EN,
      `UIF_OFS_OTG_FLAGS, `UIF_OFS_OTG_EN, `UIF_OFS_ERR_EN,
      `UIF_OFS_CTRL, `UIF_OFS_XFER_STAT};
  endfunction

  function automatic logic [31:0] exp_rd(logic [7:0] x);
    int hm;
    hm = (ctl & 1) ? 8'hff : 8'hbf;
    case (x)
      `UIF_OFS_USB_FLAGS: return (mf & hm & 8'hfd) | ((ef & ee) ? 2 : 0);
      `UIF_OFS_USB_EN: return me & hm;
      `UIF_OFS_OTG_FLAGS: return of;
      `UIF_OFS_OTG_EN: return oe;
      `UIF_OFS_ERR_EN: return ee;
      `UIF_OFS_CTRL: return ctl;
      `UIF_OFS_XFER_STAT: return q.size() ? q[0] : 0;
      default: return 0;
    endcase
  endfunction

  // Idle, activity and line-stable flags run on their own in the
  // background, so they are only compared where a test aims at them
  function automatic logic [31:0] dmask(logic [7:0] x);
    if (x == `UIF_OFS_USB_FLAGS) return 32'hffffffef;
    if (x == `UIF_OFS_OTG_FLAGS) return 32'hffffff8f;
    return 32'hffffffff;
  endfunction

  task automatic xfer(logic w, logic [7:0] x, logic [31:0] d,
    output logic [31:0] r);
    logic e;
    bit h;
    uif_cpu_model_i.xfer(w, x, d, r, e, h);
    if (h) begin
      bad_count++;
      close_out();
    end
    chk("slverr", 32'(!mapped(x)), 32'(e));
  endtask

  task automatic wr(logic [7:0] x, int d);
    logic [31:0] r;
    xfer(1'b1, x, d, r);
    case (x)
      `UIF_OFS_USB_FLAGS: begin
        mf &= ~d;
        if (d[3] && q.size()) begin
          void'(q.pop_front());
          if (q.size()) mf |= 8'h08;
        end
      end
      `UIF_OFS_USB_EN: me = d & 8'hff;
      `UIF_OFS_OTG_FLAGS: of &= ~d;
      `UIF_OFS_OTG_EN: oe = d & `UIF_OTG_MASK;
      `UIF_OFS_ERR_EN: ee = d & `UIF_ERR_MASK;
      `UIF_OFS_CTRL: ctl = d & `UIF_CTRL_MASK;
      default: ;
    endcase
  endtask

  task automatic rd(logic [7:0] x, logic [31:0] m = 0);
    logic [31:0] r;
    xfer(1'b0, x, 32'h0, r);
    if (m == 0) m = dmask(x);
    chk($sformatf("reg %h", x), exp_rd(x) & m, r & m);
  endtask

  task automatic irq_chk();
    logic x;
    repeat (3) @(posedge pclk);
    x = (exp_rd(`UIF_OFS_USB_FLAGS) & exp_rd(`UIF_OFS_USB_EN)) != 0
      || (of & oe) != 0;
    chk("irq", 32'(x), 32'(irq_o));
  endtask

  task automatic pulse(int k);
    @(posedge pclk);
    ev <= 8'h01 << k;
    token_stat_i <= $urandom;
    @(posedge pclk);
    ev <= 8'h00;
    if (k == 3 && q.size() < 4) q.push_back(token_stat_i);
    // Frame flag source follows the role: received token or threshold
    if (k >= 4) of |= EVB[k];
    else if (k != (ctl[0] ? 1 : 2)) mf |= EVB[k];
  endtask

  task automatic line(logic p, logic m, int n);
    @(posedge pclk);
    dp_i <= p;
    dm_i <= m;
    repeat (n) @(posedge pclk);
  endtask

  task automatic seterr(int v);
    @(posedge pclk);
    err_flags_i <= v;
    ef = v;
    @(posedge pclk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    ev = 8'h00;
    dp_i = 1'b1;
    dm_i = 1'b0;
    token_stat_i = 8'h00;
    err_flags_i = 8'h00;
    void'($urandom(69974));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'h04 * i);
    rd(8'h02);
    $display("test reset done");
    repeat (4) begin
      wr(`UIF_OFS_USB_EN, $urandom);
      wr(`UIF_OFS_OTG_EN, $urandom);
      wr(`UIF_OFS_ERR_EN, $urandom);
      for (int i = 1; i < 5; i++) rd(8'h04 * i);
    end
    wr(`UIF_OFS_XFER_STAT, 32'hff);
    rd(`UIF_OFS_XFER_STAT);
    wr(8'h1c, 32'hff);
    $display("test access done");
    wr(`UIF_OFS_USB_EN, 0);
    wr(`UIF_OFS_OTG_EN, 0);
    wr(`UIF_OFS_ERR_EN, 0);
    wr(`UIF_OFS_USB_FLAGS, 32'hff);
    wr(`UIF_OFS_OTG_FLAGS, 32'hff);
    for (int k = 0; k < 8; k++) begin
      a = (k < 4) ? `UIF_OFS_USB_FLAGS : `UIF_OFS_OTG_FLAGS;
      wr(a + 8'h04, EVB[k]);
      pulse(k);
      irq_chk();
      wr(a, 0);
      rd(a);
      wr(a, EVB[k]);
      irq_chk();
      rd(a);
      wr(a + 8'h04, 0);
    end
    pulse(0);
    irq_chk();
    wr(`UIF_OFS_USB_FLAGS, 8'h80);
    $display("test events done");
    for (int i = 0; i < 8; i++) begin
      seterr(8'h01 << i);
      wr(`UIF_OFS_ERR_EN, ~(8'h01 << i));
      rd(`UIF_OFS_USB_FLAGS);
      wr(`UIF_OFS_ERR_EN, 8'h01 << i);
      wr(`UIF_OFS_USB_FLAGS, 8'h02);
      rd(`UIF_OFS_USB_FLAGS);
    end
    wr(`UIF_OFS_ERR_EN, 8'h01);
    wr(`UIF_OFS_USB_EN, 8'h02);
    seterr(8'h01);
    irq_chk();
    seterr(8'h00);
    irq_chk();
    wr(`UIF_OFS_USB_EN, 0);
    $display("test error summary done");
    repeat (5) pulse(3);
    repeat (4) begin
      rd(`UIF_OFS_XFER_STAT);
      wr(`UIF_OFS_USB_FLAGS, 8'h08);
      rd(`UIF_OFS_USB_FLAGS);
    end
    rd(`UIF_OFS_XFER_STAT);
    $display("test token queue done");
    line(0, 0, LINE);
    mf |= 8'h01;
    rd(`UIF_OFS_USB_FLAGS);
    wr(`UIF_OFS_USB_FLAGS, 8'h01);
    line(0, 0, LINE);
    rd(`UIF_OFS_USB_FLAGS);
    line(0, 1, LINE);
    mf |= 8'h20;
    rd(`UIF_OFS_USB_FLAGS);
    line(1, 0, 10);
    wr(`UIF_OFS_USB_FLAGS, 8'h30);
    rd(`UIF_OFS_USB_FLAGS, 32'hffffffff);
    line(1, 0, IDLE + 10);
    mf |= 8'h10;
    rd(`UIF_OFS_USB_FLAGS, 32'hffffffff);
    wr(`UIF_OFS_CTRL, 2);
    line(0, 1, LINE);
    rd(`UIF_OFS_USB_FLAGS);
    line(1, 0, LINE);
    mf |= 8'h20;
    rd(`UIF_OFS_USB_FLAGS);
    wr(`UIF_OFS_CTRL, 0);
    wr(`UIF_OFS_OTG_FLAGS, 8'h70);
    line(0, 0, MSC + 10);
    of |= 8'h70;
    rd(`UIF_OFS_OTG_FLAGS, 32'h70);
    line(1, 0, 10);
    $display("test device line done");
    wr(`UIF_OFS_CTRL, 1);
    wr(`UIF_OFS_USB_FLAGS, 8'hff);
    wr(`UIF_OFS_USB_EN, 8'h40);
    rd(`UIF_OFS_USB_EN);
    pulse(1);
    rd(`UIF_OFS_USB_FLAGS);
    pulse(2);
    rd(`UIF_OFS_USB_FLAGS);
    line(0, 0, LINE);
    mf |= 8'h01;
    rd(`UIF_OFS_USB_FLAGS);
    wr(`UIF_OFS_USB_FLAGS, 8'h01);
    line(0, 0, LINE);
    rd(`UIF_OFS_USB_FLAGS);
    line(1, 0, 20);
    rd(`UIF_OFS_USB_FLAGS);
    line(1, 0, LINE);
    mf |= 8'h40;
    rd(`UIF_OFS_USB_FLAGS);
    irq_chk();
    wr(`UIF_OFS_CTRL, 0);
    rd(`UIF_OFS_USB_FLAGS);
    rd(`UIF_OFS_USB_EN);
    irq_chk();
    $display("test host line done");
    close_out();
  end
endmodule
